//--- i2c_port_cfg.svh
// constants for the register port: bus offsets, fields, resets, slave pattern
// assumes inclusion by bare name from the package and the modules
`ifndef I2C_PORT_CFG_SVH
`define I2C_PORT_CFG_SVH

// processor-side register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_FLAGS 8'h08

// control register fields and reset values
`define CTRL_ENABLE_BIT 0
`define CTRL_UPPER_BIT 1
`define CTRL_ENABLE_RST 1'b1
`define CTRL_UPPER_RST 1'b0

// status register field positions
`define STAT_STATE_LSB 0
`define STAT_PTR_LSB 8
`define STAT_FLAGS_LSB 16
`define STAT_READ_BIT 24
`define STAT_MATCH_BIT 25

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// serial side
`define SLAVE_PATTERN 6'h14
`define REG_COUNT 11
`define REG_LAST 4'hA
`define FLAG_REG 4'h9
`define POR_REG 4'hA
`define POR_BIT 7
`define PTR_RST 4'h0
`define BITS_PER_BYTE 4'h8

`endif

//--- i2c_port_pkg.sv
// types shared by the register port modules
// assumes the constants header sits beside it
package i2c_port_pkg;
  `include "i2c_port_cfg.svh"

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SLAVE = 3'b001,
    ST_REGADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_ACK = 3'b100,
    ST_TX = 3'b101,
    ST_TXACK = 3'b110,
    ST_SKIP = 3'b111
  } port_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } line_events_t;

  typedef struct packed {
    logic enable;
    logic upper;
  } port_ctrl_t;
endpackage

//--- line_sync.sv
// two-flop synchroniser for asynchronous pin levels
// assumes a single clock aclk with synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module line_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

//--- reg_store.sv
// small register file with registered read data and whole-array clear
// assumes one writer and one reader on aclk
`timescale 1ns/10ps
`default_nettype none
module reg_store #(
  parameter int DEPTH = 11,
  parameter int AW = 4,
  parameter int DW = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge aclk) begin
        if (!aresetn || clear) begin
          mem[i] <= '0;
        end else if (we && waddr == AW'(i)) begin
          mem[i] <= wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= '0;
    end else if (int'(raddr) < DEPTH) begin
      rdata <= mem[raddr];
    end else begin
      rdata <= '0;
    end
  end
endmodule
`default_nettype wire

//--- i2c_reg_port.sv
// serial slave port into the device register file, with a processor-side
// control and status window over AXI4-Lite
// assumes scl_in/sda_in are raw pins; the testbench resolves the open-drain wire
//
// Behaviour
// R1: bytes shift most significant bit first, bit 7 leading.
// R2: data changes only while clock is low; high-clock changes are start/stop.
// R3: watch for start at all times, ignore bus until one is seen.
// R4: a stop ends every transaction and returns the port to idle.
// R5: transmitter releases data after eight bits; receiver pulls low on ninth.
// R6: acknowledge slave byte only on address match, otherwise stay silent.
// R7: in a write, acknowledge register address and every data byte.
// R8: in a read, send eight bits, sample acknowledge, continue or stop sending.
// R9: master writes slave byte, register byte, data, then stop.
// R10: commit received data on the falling clock after its eighth bit.
// R11: advance pointer after each written byte's acknowledge; wrap after 0AH to 0.
// R12: master sets pointer by write, then repeated start with read bit 1.
// R13: master ends a read with not-acknowledge then stop.
// R14: advance pointer after shifting out eighth bit of a read byte.
// R15: slave-byte-only read starts at the pointer left by the previous access.
// R16: four general purpose flag bits, freely written, with no other effect.
// R17: flags survive sleep; a forced power-on-reset write clears them and registers.
// R18: master drives clock and starts transfers; the port never drives clock.
// R19: stop only after the transmitter released the data line.
// R20: lower device answers 0101 000x, upper 0101 001x; last bit is direction.
// R21: unmatched device disregards all bytes until the next stop; the port also leaves ST_SKIP on a repeated start.
// R22: repeated start restarts at the slave byte, pointer unchanged.
// R23: pointer is 0 until the first register write after reset.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_port_cfg.svh"
module i2c_reg_port #(
  parameter int ADDR_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic user_flag_bit0,
  output logic user_flag_bit1,
  output logic user_flag_bit2,
  output logic user_flag_bit3
);
  import i2c_port_pkg::*;

  port_state_t state;
  port_state_t after_ack;
  port_ctrl_t ctrl;
  line_events_t ev;
  logic [1:0] line_s;
  logic scl_s;
  logic sda_s;
  logic scl_prev;
  logic sda_prev;
  logic [7:0] shift;
  logic [3:0] bitcnt;
  logic [3:0] ptr;
  logic is_read;
  logic matched;
  logic bump;
  logic acked;
  logic wr_en;
  logic [7:0] wr_data;
  logic [3:0] flags;
  logic [7:0] mem_rdata;
  logic [7:0] rd_byte;
  logic por_clear;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] rd_word;
  logic rd_ok;

  // pin synchronisers; line idles high
  line_sync #(.W(2), .RST_VAL(2'b11)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({scl_in, sda_in}),
    .sync_out(line_s)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  // start/stop only while clock stays high
  always_comb begin
    ev.start = scl_s && scl_prev && sda_prev && !sda_s; // [R2] [R3]
    ev.stop = scl_s && scl_prev && !sda_prev && sda_s; // [R2] [R4]
    ev.rise = scl_s && !scl_prev;
    ev.fall = !scl_s && scl_prev;
  end

  function automatic logic [3:0] next_ptr(input logic [3:0] p);
    next_ptr = (p >= `REG_LAST) ? 4'h0 : p + 4'h1; // [R11]
  endfunction

  assign rd_byte = (ptr == `FLAG_REG) ? {4'h0, flags} : mem_rdata;
  assign por_clear = wr_en && ptr == `POR_REG && wr_data[`POR_BIT];

  // serial protocol engine; clock is only ever sampled, never driven
  always_ff @(posedge aclk) begin // [R18]
    if (!aresetn) begin
      state <= ST_IDLE;
      after_ack <= ST_IDLE;
      shift <= 8'h00;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      ptr <= `PTR_RST; // [R23]
      is_read <= 1'b0;
      matched <= 1'b0;
      bump <= 1'b0;
      acked <= 1'b0;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      sda_out <= 1'b0;
      if (!ctrl.enable || ev.stop) begin
        state <= ST_IDLE; // [R4] [R19]
        sda_oe <= 1'b0;
      end else if (ev.start) begin
        state <= ST_SLAVE; // [R3] [R22]
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_SLAVE, ST_REGADDR, ST_WDATA: begin
            if (ev.rise && bitcnt != `BITS_PER_BYTE) begin
              shift <= {shift[6:0], sda_s}; // [R1]
              bitcnt <= bitcnt + 4'h1;
            end else if (ev.fall && bitcnt == `BITS_PER_BYTE) begin
              bitcnt <= 4'h0;
              case (state)
                ST_SLAVE: begin
                  if (shift[7:1] == {`SLAVE_PATTERN, ctrl.upper}) begin // [R20]
                    matched <= 1'b1;
                    is_read <= shift[0];
                    sda_oe <= 1'b1; // [R5] [R6]
                    after_ack <= shift[0] ? ST_TX : ST_REGADDR; // [R15]
                    bump <= 1'b0;
                    state <= ST_ACK;
                  end else begin
                    matched <= 1'b0;
                    state <= ST_SKIP; // [R6] [R21]
                  end
                end
                ST_REGADDR: begin
                  ptr <= shift[3:0];
                  sda_oe <= 1'b1; // [R7]
                  after_ack <= ST_WDATA;
                  bump <= 1'b0;
                  state <= ST_ACK;
                end
                default: begin
                  wr_en <= 1'b1; // [R10]
                  wr_data <= shift;
                  sda_oe <= 1'b1; // [R7]
                  after_ack <= ST_WDATA;
                  bump <= 1'b1;
                  state <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (ev.fall) begin
              sda_oe <= 1'b0; // [R5]
              if (bump) begin
                ptr <= next_ptr(ptr); // [R11]
              end
              if (after_ack == ST_TX) begin
                shift <= rd_byte;
                sda_oe <= ~rd_byte[7]; // [R1]
                bitcnt <= 4'h0;
              end
              state <= after_ack;
            end
          end
          ST_TX: begin
            if (ev.rise) begin
              bitcnt <= bitcnt + 4'h1;
            end else if (ev.fall) begin
              if (bitcnt == `BITS_PER_BYTE) begin
                sda_oe <= 1'b0; // [R8]
                ptr <= next_ptr(ptr); // [R14]
                acked <= 1'b0;
                state <= ST_TXACK;
              end else begin
                shift <= {shift[6:0], 1'b0};
                sda_oe <= ~shift[6];
              end
            end
          end
          ST_TXACK: begin
            if (ev.rise) begin
              acked <= ~sda_s;
            end else if (ev.fall) begin
              if (acked) begin
                shift <= rd_byte; // [R8]
                sda_oe <= ~rd_byte[7];
                bitcnt <= 4'h0;
                state <= ST_TX;
              end else begin
                state <= ST_SKIP; // [R8] [R13]
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // register file behind the serial pointer
  reg_store #(.DEPTH(`REG_COUNT), .AW(4), .DW(8)) u_store (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(por_clear),
    .we(wr_en),
    .waddr(ptr),
    .wdata(wr_data),
    .raddr(ptr),
    .rdata(mem_rdata)
  );

  // general purpose flags, untouched by sleep, cleared by forced reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= 4'h0;
    end else if (por_clear) begin
      flags <= 4'h0; // [R17]
    end else if (wr_en && ptr == `FLAG_REG) begin
      flags <= wr_data[3:0]; // [R16]
    end
  end

  assign user_flag_bit0 = flags[0];
  assign user_flag_bit1 = flags[1];
  assign user_flag_bit2 = flags[2];
  assign user_flag_bit3 = flags[3];

  // processor write channels; address and data held until both arrive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      ctrl.enable <= `CTRL_ENABLE_RST;
      ctrl.upper <= `CTRL_UPPER_RST;
    end else begin
      if (awvalid && awready) begin
        awaddr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready <= 1'b0;
      end
      if (!awready && !wready && !bvalid) begin
        bvalid <= 1'b1;
        if (awaddr_q == `OFS_CTRL) begin
          bresp <= `RESP_OKAY;
          if (wstrb_q[0]) begin
            ctrl.enable <= wdata_q[`CTRL_ENABLE_BIT];
            ctrl.upper <= wdata_q[`CTRL_UPPER_BIT];
          end
        end else if (awaddr_q == `OFS_STATUS || awaddr_q == `OFS_FLAGS) begin
          bresp <= `RESP_OKAY;
        end else begin
          bresp <= `RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // read decode
  always_comb begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    case (araddr)
      `OFS_CTRL: begin
        rd_word[`CTRL_ENABLE_BIT] = ctrl.enable;
        rd_word[`CTRL_UPPER_BIT] = ctrl.upper;
      end
      `OFS_STATUS: begin
        rd_word[`STAT_STATE_LSB +: 3] = state;
        rd_word[`STAT_PTR_LSB +: 4] = ptr;
        rd_word[`STAT_FLAGS_LSB +: 4] = flags;
        rd_word[`STAT_READ_BIT] = is_read;
        rd_word[`STAT_MATCH_BIT] = matched;
      end
      `OFS_FLAGS: begin
        rd_word[3:0] = flags;
      end
      default: begin
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_word;
        rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- i2c_reg_port_asserts.sv
// checker for the serial register port: link pins and bus handshakes
// assumes binding onto i2c_reg_port, one clock aclk
`timescale 1ns/10ps
`default_nettype none
module i2c_reg_port_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic user_flag_bit0,
  input wire logic user_flag_bit1,
  input wire logic user_flag_bit2,
  input wire logic user_flag_bit3
);
  logic scl_q, sda_q, framed;
  wire logic [3:0] flags = {user_flag_bit3, user_flag_bit2, user_flag_bit1, user_flag_bit0};
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
  end
  // raw-pin frame tracker: set by start, cleared by stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      framed <= 1'b0;
    end else if (scl_in && scl_q && sda_q != sda_in) begin
      framed <= sda_q;
    end
  end
  property p_silent_idle; !framed |-> !sda_oe; endproperty
  a_silent_idle: assert property (p_silent_idle)
    else $error("data driven outside a frame");
  property p_oe_low_clock; $changed(sda_oe) |-> !$past(scl_in, 2); endproperty
  a_oe_low_clock: assert property (p_oe_low_clock)
    else $error("data changed with clock high");
  property p_drive_low; sda_out == 1'b0; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("data output not low");
  property p_flag_commit; $changed(flags) |-> framed && !$past(scl_in, 2); endproperty
  a_flag_commit: assert property (p_flag_commit)
    else $error("flags moved off a falling clock");
  property p_write_answer; awvalid && awready && wvalid && wready |=> ##1 bvalid; endproperty
  a_write_answer: assert property (p_write_answer)
    else $error("write response late");
  property p_one_write; bvalid |-> !awready && !wready; endproperty
  a_one_write: assert property (p_one_write)
    else $error("write taken during response");
  property p_read_answer; arvalid && arready |=> rvalid && !arready; endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read response late");
  property p_read_once; rvalid && rready |=> !rvalid ##1 arready; endproperty
  a_read_once: assert property (p_read_once)
    else $error("read response repeated");
  c_frame: cover property ($rose(framed));
  c_ack: cover property ($rose(sda_oe));
  c_write: cover property (bvalid);
endmodule
bind i2c_reg_port i2c_reg_port_asserts u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .arvalid, .arready, .rvalid, .rready, .scl_in, .sda_in, .sda_out, .sda_oe,
  .user_flag_bit0, .user_flag_bit1, .user_flag_bit2, .user_flag_bit3);
`default_nettype wire

//--- i2c_master_model.sv
// serial bus master model, 8 aclk per bit
// assumes an open-drain data wire with pull-up resolved by the bench
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
  input wire logic aclk,
  input wire logic sda,
  output logic scl,
  output logic m_oe
);
  // clock rests high between frames
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  task automatic q;
    repeat (2) @(posedge aclk);
  endtask
  task automatic start;
    m_oe <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    m_oe <= 1'b1;
    q;
    scl <= 1'b0;
    q;
  endtask
  // line released by the sender first
  task automatic stop;
    m_oe <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    m_oe <= 1'b0;
    q;
  endtask
  // data set mid-low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    m_oe <= ~b;
    q;
    scl <= 1'b1;
    q;
    r = sda;
    q;
    scl <= 1'b0;
    q;
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
    output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(nine, r);
    ak = ~r;
  endtask
endmodule
`default_nettype wire

//--- i2c_slave_register_port_bench.sv
// self-checking bench for the serial register port
// assumes the master model and checker files compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "i2c_port_cfg.svh"
module i2c_slave_register_port_bench;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, scl, m_oe, sda_oe, up, ak;
  logic [7:0] awaddr, araddr, rx;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  wire logic [3:0] flags;
  logic [3:0] ra, mptr;
  logic [7:0] mreg [0:10];
  wire logic sda_line = ~(sda_oe | m_oe);
  int fails, num_checks, seed, n;
  i2c_reg_port dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe,
    .user_flag_bit0(flags[0]), .user_flag_bit1(flags[1]), .user_flag_bit2(flags[2]),
    .user_flag_bit3(flags[3]));
  i2c_master_model m (.aclk, .sda(sda_line), .scl, .m_oe);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic [3:0] inc(input logic [3:0] p);
    return (p == `REG_LAST) ? 4'h0 : p + 4'h1;
  endfunction
  function automatic logic [7:0] sbyte(input logic rdn);
    return {`SLAVE_PATTERN, up, rdn};
  endfunction
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task automatic swrite(input logic [3:0] a, input int cnt, input logic por);
    logic [7:0] d;
    m.start;
    m.byte_io(sbyte(1'b0), 1'b1, rx, ak);
    chk(32'(ak), 32'h1);
    m.byte_io({4'h0, a}, 1'b1, rx, ak);
    chk(32'(ak), 32'h1);
    mptr = a;
    repeat (cnt) begin
      d = 8'($random(seed));
      if (mptr == `POR_REG) d[`POR_BIT] = por;
      m.byte_io(d, 1'b1, rx, ak);
      chk(32'(ak), 32'h1);
      if (mptr == `POR_REG && por) begin
        foreach (mreg[i]) mreg[i] = 8'h00;
      end else begin
        mreg[mptr] = (mptr == `FLAG_REG) ? {4'h0, d[3:0]} : d;
      end
      mptr = inc(mptr);
    end
    m.stop;
  endtask
  task automatic sread(input logic set, input logic [3:0] a, input int cnt);
    m.start;
    if (set) begin
      m.byte_io(sbyte(1'b0), 1'b1, rx, ak);
      m.byte_io({4'h0, a}, 1'b1, rx, ak);
      mptr = a;
      m.start;
    end
    m.byte_io(sbyte(1'b1), 1'b1, rx, ak);
    chk(32'(ak), 32'h1);
    for (int i = 1; i <= cnt; i++) begin
      m.byte_io(8'hFF, i == cnt, rx, ak);
      chk(32'(rx), 32'(mreg[mptr]));
      mptr = inc(mptr);
    end
    m.stop;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    fails++;
    summarize;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, up} = '0;
    {awaddr, araddr, wdata} = '0;
    fails = 0;
    num_checks = 0;
    seed = 32'hD10626FC;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`OFS_CTRL);
    chk(rd, 32'h1);
    axi_rd(`OFS_STATUS);
    chk(32'(rd[11:8]), 32'h0);
    axi_rd(8'h0C);
    chk(rd, 32'h0);
    chk(32'(rs), 32'(`RESP_SLVERR));
    axi_wr(8'h10, 32'hFFFFFFFF);
    chk(32'(rs), 32'(`RESP_SLVERR));
    swrite(`FLAG_REG, 1, 1'b0);
    chk(32'(flags), 32'(mreg[`FLAG_REG][3:0]));
    axi_rd(`OFS_FLAGS);
    chk(rd, 32'(mreg[`FLAG_REG][3:0]));
    swrite(`FLAG_REG, 2, 1'b1);
    chk(32'(flags), 32'h0);
    sread(1'b1, `FLAG_REG, 3);
    sread(1'b0, 4'h0, 1);
    repeat (4) begin
      ra = 4'($unsigned($random(seed)) % 11);
      n = 1 + $unsigned($random(seed)) % 4;
      swrite(ra, n, 1'b0);
      chk(32'(flags), 32'(mreg[`FLAG_REG][3:0]));
      sread(1'b1, ra, n);
      sread(1'b0, ra, 1);
    end
    for (int u = 0; u < 2; u++) begin
      axi_wr(`OFS_CTRL, 32'(1 + 2 * u));
      up = u[0];
      m.start;
      m.byte_io(sbyte(1'b0) ^ 8'h02, 1'b1, rx, ak);
      chk(32'(ak), 32'h0);
      m.byte_io(8'h00, 1'b1, rx, ak);
      chk(32'(ak), 32'h0);
      m.stop;
      axi_rd(`OFS_STATUS);
      chk(32'(rd[11:8]), 32'(mptr));
      swrite(4'h3, 1, 1'b0);
      sread(1'b1, 4'h3, 1);
    end
    summarize;
  end
endmodule
`default_nettype wire
